// ===== logic/irq_agg_pkg.sv
// Constants, register map and carrier types of the peripheral interrupt aggregator.
// Assumes a single core clock domain shared with all event sources.
package irq_agg_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned VEC_W  = 16;
  localparam int unsigned PRIO_W = 5;
  localparam int unsigned NSRC   = 5;
  localparam int unsigned SRC_W  = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_SRC_MASK  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_SRC_PEND  = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_PEND_LOW  = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_EN_LOW    = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_PEND_HIGH = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_EN_HIGH   = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_SERVICE   = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_SELECT    = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 4'h9;

  // Source mask / pending layout
  localparam int unsigned PS_W    = 4;
  localparam int unsigned PS_CMP5 = 0;
  localparam int unsigned PS_WG   = 1;
  localparam int unsigned PS_TMR1 = 2;
  localparam int unsigned PS_TMR2 = 3;

  // High pending / enable / select layout, and arbiter source index
  localparam int unsigned HI_W     = 4;
  localparam int unsigned HI_PGRP  = 0;
  localparam int unsigned HI_CC4   = 1;
  localparam int unsigned HI_CMP4  = 2;
  localparam int unsigned HI_CC5   = 3;
  localparam int unsigned SRC_TIMER_OVERFLOW_GROUP_FLAG = 4;
  localparam int unsigned LO_W     = 1;
  localparam int unsigned LO_TIMER_OVERFLOW_GROUP_FLAG  = 0;
  localparam int unsigned SV_W     = 1;
  localparam int unsigned SV_PGRP  = 0;

  localparam logic [PS_W-1:0]   PS_RST = 4'h0;
  localparam logic [HI_W-1:0]   HI_RST = 4'h0;
  localparam logic [LO_W-1:0]   LO_RST = 1'h0;
  localparam logic [NSRC-1:0]   IRQ_RST = 5'h00;
  localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;

  // Vectors and priorities
  localparam logic [VEC_W-1:0]  CC5_INT_VEC   = 16'h2038;
  localparam logic [PRIO_W-1:0] CC5_INT_PRIO  = 5'h0C;
  localparam logic [VEC_W-1:0]  CC5_SRV_VEC   = 16'h2058;
  localparam logic [PRIO_W-1:0] CC5_SRV_PRIO  = 5'h1B;
  localparam logic [VEC_W-1:0]  CMP4_INT_VEC  = 16'h2036;
  localparam logic [PRIO_W-1:0] CMP4_INT_PRIO = 5'h0B;
  localparam logic [VEC_W-1:0]  CMP4_SRV_VEC  = 16'h2056;
  localparam logic [PRIO_W-1:0] CMP4_SRV_PRIO = 5'h1A;
  localparam logic [VEC_W-1:0]  CC4_INT_VEC   = 16'h2034;
  localparam logic [PRIO_W-1:0] CC4_INT_PRIO  = 5'h0A;
  localparam logic [VEC_W-1:0]  CC4_SRV_VEC   = 16'h2054;
  localparam logic [PRIO_W-1:0] CC4_SRV_PRIO  = 5'h19;
  // Group slots: plain defaults, not fixed by anything here
  localparam logic [VEC_W-1:0]  PGRP_INT_VEC  = 16'h2030;
  localparam logic [PRIO_W-1:0] PGRP_INT_PRIO = 5'h09;
  localparam logic [VEC_W-1:0]  PGRP_SRV_VEC  = 16'h2050;
  localparam logic [PRIO_W-1:0] PGRP_SRV_PRIO = 5'h18;
  localparam logic [VEC_W-1:0]  TIMER_OVERFLOW_GROUP_FLAG_INT_VEC  = 16'h2008;
  localparam logic [PRIO_W-1:0] TIMER_OVERFLOW_GROUP_FLAG_INT_PRIO = 5'h04;

  typedef struct packed {
    logic              valid;
    logic              server;
    logic [SRC_W-1:0]  src;
    logic [VEC_W-1:0]  addr;
    logic [PRIO_W-1:0] prio;
  } vector_t;

  typedef struct packed {
    logic [NSRC-1:0] req;
    logic [NSRC-1:0] route_srv;
  } arb_req_t;

endpackage : irq_agg_pkg

// ===== logic/sticky_flags.sv
// Bank of sticky flags: a set in the same cycle as a clear wins.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module sticky_flags #(
  parameter int unsigned W = 4
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  output var  logic [W-1:0] q_out
);

  logic [W-1:0] nxt_q;

  assign nxt_q = (q_out & ~clr_in) | set_in;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q_out <= '0;
    end else begin
      q_out <= nxt_q;
    end
  end

endmodule : sticky_flags
`default_nettype wire

// ===== logic/vector_arbiter.sv
// Picks the highest-priority request and its vector and priority.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
module vector_arbiter (
  input  wire logic                 req_in_valid,
  input  wire irq_agg_pkg::arb_req_t reqs_in,
  output var  irq_agg_pkg::vector_t  pick_out
);

  function automatic irq_agg_pkg::vector_t slot(
    input logic [irq_agg_pkg::SRC_W-1:0] idx,
    input logic srv
  );
    irq_agg_pkg::vector_t v;
    v = '0;
    v.valid  = 1'b1;
    v.server = srv;
    v.src    = idx;
    unique case (idx)
      3'h0: begin
        v.addr = srv ? irq_agg_pkg::PGRP_SRV_VEC : irq_agg_pkg::PGRP_INT_VEC;
        v.prio = srv ? irq_agg_pkg::PGRP_SRV_PRIO : irq_agg_pkg::PGRP_INT_PRIO;
      end
      3'h1: begin
        v.addr = srv ? irq_agg_pkg::CC4_SRV_VEC : irq_agg_pkg::CC4_INT_VEC;
        v.prio = srv ? irq_agg_pkg::CC4_SRV_PRIO : irq_agg_pkg::CC4_INT_PRIO;
      end
      3'h2: begin
        v.addr = srv ? irq_agg_pkg::CMP4_SRV_VEC : irq_agg_pkg::CMP4_INT_VEC;
        v.prio = srv ? irq_agg_pkg::CMP4_SRV_PRIO : irq_agg_pkg::CMP4_INT_PRIO;
      end
      3'h3: begin
        v.addr = srv ? irq_agg_pkg::CC5_SRV_VEC : irq_agg_pkg::CC5_INT_VEC;
        v.prio = srv ? irq_agg_pkg::CC5_SRV_PRIO : irq_agg_pkg::CC5_INT_PRIO;
      end
      default: begin
        v.addr   = irq_agg_pkg::TIMER_OVERFLOW_GROUP_FLAG_INT_VEC;
        v.prio   = irq_agg_pkg::TIMER_OVERFLOW_GROUP_FLAG_INT_PRIO;
        v.server = 1'b0;
      end
    endcase
    return v;
  endfunction : slot

  always_comb begin
    irq_agg_pkg::vector_t best;
    irq_agg_pkg::vector_t cand;
    best = '0;
    cand = '0;
    for (int i = 0; i < irq_agg_pkg::NSRC; i++) begin
      cand = slot(i[irq_agg_pkg::SRC_W-1:0], reqs_in.route_srv[i]);
      if (req_in_valid && reqs_in.req[i] && (!best.valid || cand.prio > best.prio)) begin
        best = cand;
      end
    end
    pick_out = best;
  end

endmodule : vector_arbiter
`default_nettype wire

// ===== logic/peripheral_interrupt_aggregator.sv
// Peripheral interrupt aggregation, vectoring and register file.
// Assumes event and server-done pulses from logic on clk_in, one cycle each,
// and a CPU that pulses take_in once for the vector it accepts.
// Notes on behaviour
// - Masked waveform or compare-5 event sets group flag
// - Group request needs group enable and source mask
// - Masked timer overflow sets timer group flag
// - Timer request needs timer enable and source mask
// - Reading source pending clears it entirely
// - Masked server cycle end sets group service bit
// - Select bit routes group to server vector
// - Group vector taken only while group enabled
// - Source mask and pending: one bit per source
// - Channel 5: 2038H prio 12, 2058H prio 27
// - Compare 4: 2036H prio 11, 2056H prio 26
// - Channel 4: 2034H prio 10, 2054H prio 25
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module peripheral_interrupt_aggregator (
  input  wire logic                           clk_in,
  input  wire logic                           resetn_in,
  // Register port
  input  wire logic [irq_agg_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [irq_agg_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                           wr_in,
  input  wire logic                           rd_in,
  output var  logic [irq_agg_pkg::DATA_W-1:0] rdata_out,
  // Event sources
  input  wire logic                           compare_ch5_evt_in,
  input  wire logic                           waveform_gen_evt_in,
  input  wire logic                           timer_one_ovf_in,
  input  wire logic                           timer_two_ovf_in,
  input  wire logic                           capture_compare_ch4_evt_in,
  input  wire logic                           compare_ch4_evt_in,
  input  wire logic                           capture_compare_ch5_evt_in,
  // Transaction server cycle ends
  input  wire logic                           server_done_ch5_in,
  input  wire logic                           server_done_wg_in,
  // CPU side
  input  wire logic                           take_in,
  output var  irq_agg_pkg::vector_t           vector_out,
  output var  logic                           irq_out
);

  // Registers
  logic [irq_agg_pkg::PS_W-1:0] peripheral_source_mask_ff;
  logic [irq_agg_pkg::PS_W-1:0] nxt_peripheral_source_mask;
  logic [irq_agg_pkg::LO_W-1:0] interrupt_enable_low_ff;
  logic [irq_agg_pkg::LO_W-1:0] nxt_interrupt_enable_low;
  logic [irq_agg_pkg::HI_W-1:0] interrupt_enable_high_ff;
  logic [irq_agg_pkg::HI_W-1:0] nxt_interrupt_enable_high;
  logic [irq_agg_pkg::HI_W-1:0] transaction_select_flags_ff;
  logic [irq_agg_pkg::HI_W-1:0] nxt_transaction_select_flags;
  logic [irq_agg_pkg::NSRC-1:0] irq_mask_ff;
  logic [irq_agg_pkg::NSRC-1:0] nxt_irq_mask;
  logic [irq_agg_pkg::DATA_W-1:0] nxt_rdata;
  logic                         nxt_irq;
  irq_agg_pkg::vector_t         nxt_vector;

  // Flag banks
  logic [irq_agg_pkg::PS_W-1:0] peripheral_source_pending;
  logic [irq_agg_pkg::PS_W-1:0] src_set;
  logic [irq_agg_pkg::PS_W-1:0] src_clr;
  logic [irq_agg_pkg::HI_W-1:0] interrupt_pending_high;
  logic [irq_agg_pkg::HI_W-1:0] hi_set;
  logic [irq_agg_pkg::HI_W-1:0] hi_clr;
  logic [irq_agg_pkg::LO_W-1:0] interrupt_pending_low;
  logic [irq_agg_pkg::LO_W-1:0] lo_set;
  logic [irq_agg_pkg::LO_W-1:0] lo_clr;
  logic [irq_agg_pkg::SV_W-1:0] transaction_service_flags;
  logic [irq_agg_pkg::SV_W-1:0] sv_set;
  logic [irq_agg_pkg::SV_W-1:0] sv_clr;
  logic [irq_agg_pkg::NSRC-1:0] irq_status;
  logic [irq_agg_pkg::NSRC-1:0] st_set;
  logic [irq_agg_pkg::NSRC-1:0] st_clr;

  // Decode
  function automatic logic hit(
    input logic [irq_agg_pkg::ADDR_W-1:0] a,
    input logic [irq_agg_pkg::ADDR_W-1:0] ofs
  );
    return a == ofs;
  endfunction : hit

  wire wr_mask   = wr_in && hit(addr_in, irq_agg_pkg::OFS_SRC_MASK);
  wire rd_pend   = rd_in && hit(addr_in, irq_agg_pkg::OFS_SRC_PEND);
  wire wr_plow   = wr_in && hit(addr_in, irq_agg_pkg::OFS_PEND_LOW);
  wire wr_enlow  = wr_in && hit(addr_in, irq_agg_pkg::OFS_EN_LOW);
  wire wr_phigh  = wr_in && hit(addr_in, irq_agg_pkg::OFS_PEND_HIGH);
  wire wr_enhigh = wr_in && hit(addr_in, irq_agg_pkg::OFS_EN_HIGH);
  wire wr_serv   = wr_in && hit(addr_in, irq_agg_pkg::OFS_SERVICE);
  wire wr_sel    = wr_in && hit(addr_in, irq_agg_pkg::OFS_SELECT);
  wire wr_stat   = wr_in && hit(addr_in, irq_agg_pkg::OFS_IRQ_STAT);
  wire wr_imask  = wr_in && hit(addr_in, irq_agg_pkg::OFS_IRQ_MASK);

  // Masked source events, one bit per source
  wire [irq_agg_pkg::PS_W-1:0] raw_evt = {timer_two_ovf_in, timer_one_ovf_in,
                                          waveform_gen_evt_in, compare_ch5_evt_in};
  wire [irq_agg_pkg::PS_W-1:0] masked_evt = raw_evt & peripheral_source_mask_ff;

  wire pgrp_evt = masked_evt[irq_agg_pkg::PS_WG] |
                  masked_evt[irq_agg_pkg::PS_CMP5];
  wire timer_overflow_group_flag_evt = masked_evt[irq_agg_pkg::PS_TMR1] |
                  masked_evt[irq_agg_pkg::PS_TMR2];
  wire srv_evt  = (server_done_wg_in & peripheral_source_mask_ff[irq_agg_pkg::PS_WG]) |
                  (server_done_ch5_in & peripheral_source_mask_ff[irq_agg_pkg::PS_CMP5]);

  // Source pending: set wins over the read that clears it
  assign src_set = masked_evt;
  assign src_clr = rd_pend ? {irq_agg_pkg::PS_W{1'b1}} : '0;

  // Vector taken clears the source it belongs to
  wire [irq_agg_pkg::NSRC-1:0] take_vec =
    (take_in && vector_out.valid) ? irq_agg_pkg::NSRC'(1) << vector_out.src : '0;

  assign hi_set = {capture_compare_ch5_evt_in, compare_ch4_evt_in,
                   capture_compare_ch4_evt_in, pgrp_evt};
  // Software clears a flag by writing zero to it
  assign hi_clr = (wr_phigh ? ~wdata_in[irq_agg_pkg::HI_W-1:0] : '0) |
                  take_vec[irq_agg_pkg::HI_W-1:0];
  assign lo_set = timer_overflow_group_flag_evt;
  assign lo_clr = (wr_plow ? ~wdata_in[irq_agg_pkg::LO_W-1:0] : '0) |
                  take_vec[irq_agg_pkg::SRC_TIMER_OVERFLOW_GROUP_FLAG];
  assign sv_set = srv_evt;
  assign sv_clr = wr_serv ? ~wdata_in[irq_agg_pkg::SV_W-1:0] : '0;

  // Interrupt status: set by any event that sets a group or channel flag
  assign st_set = {timer_overflow_group_flag_evt, hi_set};
  assign st_clr = wr_stat ? wdata_in[irq_agg_pkg::NSRC-1:0] : '0;

  sticky_flags #(.W(irq_agg_pkg::PS_W)) u_src_pend (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .set_in    (src_set),
    .clr_in    (src_clr),
    .q_out     (peripheral_source_pending)
  );

  sticky_flags #(.W(irq_agg_pkg::HI_W)) u_pend_high (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .set_in    (hi_set),
    .clr_in    (hi_clr),
    .q_out     (interrupt_pending_high)
  );

  sticky_flags #(.W(irq_agg_pkg::LO_W)) u_pend_low (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .set_in    (lo_set),
    .clr_in    (lo_clr),
    .q_out     (interrupt_pending_low)
  );

  sticky_flags #(.W(irq_agg_pkg::SV_W)) u_service (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .set_in    (sv_set),
    .clr_in    (sv_clr),
    .q_out     (transaction_service_flags)
  );

  sticky_flags #(.W(irq_agg_pkg::NSRC)) u_irq_stat (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .set_in    (st_set),
    .clr_in    (st_clr),
    .q_out     (irq_status)
  );

  // Writable registers; reserved bits are dropped on write
  assign nxt_peripheral_source_mask = wr_mask ? wdata_in[irq_agg_pkg::PS_W-1:0]
                                              : peripheral_source_mask_ff;
  assign nxt_interrupt_enable_low   = wr_enlow ? wdata_in[irq_agg_pkg::LO_W-1:0]
                                               : interrupt_enable_low_ff;
  assign nxt_interrupt_enable_high  = wr_enhigh ? wdata_in[irq_agg_pkg::HI_W-1:0]
                                                : interrupt_enable_high_ff;
  assign nxt_transaction_select_flags = wr_sel ? wdata_in[irq_agg_pkg::HI_W-1:0]
                                               : transaction_select_flags_ff;
  assign nxt_irq_mask = wr_imask ? wdata_in[irq_agg_pkg::NSRC-1:0] : irq_mask_ff;

  // Arbitration: pending and enabled, minus whatever is being taken now,
  // so one acceptance never shows the same vector twice
  irq_agg_pkg::arb_req_t arb_reqs;
  irq_agg_pkg::vector_t  arb_pick;

  wire [irq_agg_pkg::HI_W-1:0] hi_req = interrupt_pending_high & interrupt_enable_high_ff;
  wire lo_req = interrupt_pending_low[irq_agg_pkg::LO_TIMER_OVERFLOW_GROUP_FLAG] &
                interrupt_enable_low_ff[irq_agg_pkg::LO_TIMER_OVERFLOW_GROUP_FLAG];

  assign arb_reqs.req = {lo_req, hi_req} & ~take_vec;
  assign arb_reqs.route_srv = {1'b0, transaction_select_flags_ff};

  vector_arbiter u_arb (
    .req_in_valid (1'b1),
    .reqs_in      (arb_reqs),
    .pick_out     (arb_pick)
  );

  assign nxt_vector = arb_pick;
  assign nxt_irq    = |(irq_status & irq_mask_ff);

  // Read mux; unmapped offsets and reserved bits read zero
  logic [irq_agg_pkg::DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = irq_agg_pkg::RD_ZERO;
    unique case (addr_in)
      irq_agg_pkg::OFS_SRC_MASK:  rd_mux[irq_agg_pkg::PS_W-1:0] = peripheral_source_mask_ff;
      irq_agg_pkg::OFS_SRC_PEND:  rd_mux[irq_agg_pkg::PS_W-1:0] = peripheral_source_pending;
      irq_agg_pkg::OFS_PEND_LOW:  rd_mux[irq_agg_pkg::LO_W-1:0] = interrupt_pending_low;
      irq_agg_pkg::OFS_EN_LOW:    rd_mux[irq_agg_pkg::LO_W-1:0] = interrupt_enable_low_ff;
      irq_agg_pkg::OFS_PEND_HIGH: rd_mux[irq_agg_pkg::HI_W-1:0] = interrupt_pending_high;
      irq_agg_pkg::OFS_EN_HIGH:   rd_mux[irq_agg_pkg::HI_W-1:0] = interrupt_enable_high_ff;
      irq_agg_pkg::OFS_SERVICE:   rd_mux[irq_agg_pkg::SV_W-1:0] = transaction_service_flags;
      irq_agg_pkg::OFS_SELECT:    rd_mux[irq_agg_pkg::HI_W-1:0] = transaction_select_flags_ff;
      irq_agg_pkg::OFS_IRQ_STAT:  rd_mux[irq_agg_pkg::NSRC-1:0] = irq_status;
      irq_agg_pkg::OFS_IRQ_MASK:  rd_mux[irq_agg_pkg::NSRC-1:0] = irq_mask_ff;
      default:                    rd_mux = irq_agg_pkg::RD_ZERO;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  assign nxt_rdata = rd_in ? rd_mux : irq_agg_pkg::RD_ZERO;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      peripheral_source_mask_ff   <= irq_agg_pkg::PS_RST;
      interrupt_enable_low_ff     <= irq_agg_pkg::LO_RST;
      interrupt_enable_high_ff    <= irq_agg_pkg::HI_RST;
      transaction_select_flags_ff <= irq_agg_pkg::HI_RST;
      irq_mask_ff                 <= irq_agg_pkg::IRQ_RST;
    end else begin
      peripheral_source_mask_ff   <= nxt_peripheral_source_mask;
      interrupt_enable_low_ff     <= nxt_interrupt_enable_low;
      interrupt_enable_high_ff    <= nxt_interrupt_enable_high;
      transaction_select_flags_ff <= nxt_transaction_select_flags;
      irq_mask_ff                 <= nxt_irq_mask;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out  <= irq_agg_pkg::RD_ZERO;
      vector_out <= '0;
      irq_out    <= 1'b0;
    end else begin
      rdata_out  <= nxt_rdata;
      vector_out <= nxt_vector;
      irq_out    <= nxt_irq;
    end
  end

endmodule : peripheral_interrupt_aggregator
`default_nettype wire

// ===== verif/irq_agg_checker.sv
// Port-level checks of the peripheral interrupt aggregator.
// Assumes one core clock and the register map of irq_agg_pkg.
`timescale 1ns/1ns
`default_nettype none
module irq_agg_checker (
  input wire logic                 clk_in,
  input wire logic                 resetn_in,
  input wire logic [3:0]           addr_in,
  input wire logic [7:0]           wdata_in,
  input wire logic                 wr_in,
  input wire logic                 rd_in,
  input wire logic [7:0]           rdata_out,
  input wire logic                 compare_ch5_evt_in,
  input wire logic                 waveform_gen_evt_in,
  input wire logic                 timer_one_ovf_in,
  input wire logic                 timer_two_ovf_in,
  input wire logic                 capture_compare_ch4_evt_in,
  input wire logic                 compare_ch4_evt_in,
  input wire logic                 capture_compare_ch5_evt_in,
  input wire logic                 take_in,
  input wire irq_agg_pkg::vector_t vector_out
);
  // Channel events bypass the source pending register
  wire logic       src_evt = compare_ch5_evt_in | waveform_gen_evt_in | timer_one_ovf_in |
                             timer_two_ovf_in;
  wire logic       cause   = src_evt | capture_compare_ch4_evt_in | compare_ch4_evt_in |
                             capture_compare_ch5_evt_in | wr_in;
  wire logic       srv     = vector_out.server;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_cc5_vector: assert property (
    vector_out.valid && vector_out.src == 3'h3 |->
      vector_out.addr == (srv ? 16'h2058 : 16'h2038) &&
      vector_out.prio == (srv ? 5'h1B : 5'h0C))
    else $error("bad channel 5 vector");
  a_cmp4_vector: assert property (
    vector_out.valid && vector_out.src == 3'h2 |->
      vector_out.addr == (srv ? 16'h2056 : 16'h2036) &&
      vector_out.prio == (srv ? 5'h1A : 5'h0B))
    else $error("bad compare 4 vector");
  a_cc4_vector: assert property (
    vector_out.valid && vector_out.src == 3'h1 |->
      vector_out.addr == (srv ? 16'h2054 : 16'h2034) &&
      vector_out.prio == (srv ? 5'h19 : 5'h0A))
    else $error("bad channel 4 vector");
  a_timer_overflow_group_flag_plain: assert property (
    vector_out.valid && vector_out.src == 3'h4 |-> !srv)
    else $error("timer group on server");
  a_pend_read_clear: assert property (
    (rd_in && addr_in == irq_agg_pkg::OFS_SRC_PEND && !src_evt) ##1
    (rd_in && addr_in == irq_agg_pkg::OFS_SRC_PEND) |=> rdata_out == 8'h00)
    else $error("pending not cleared");
  a_take_excludes: assert property (
    take_in && vector_out.valid |=>
      !(vector_out.valid && vector_out.src == $past(vector_out.src)))
    else $error("taken vector shown again");
  a_vector_cause: assert property (
    $rose(vector_out.valid) |-> $past(cause, 2))
    else $error("vector without cause");
  a_mask_readback: assert property (
    (wr_in && addr_in == irq_agg_pkg::OFS_SRC_MASK) ##1 !wr_in ##1
    (rd_in && addr_in == irq_agg_pkg::OFS_SRC_MASK) |=>
      rdata_out == {4'h0, $past(wdata_in[3:0], 3)})
    else $error("mask read back wrong");
endmodule : irq_agg_checker

bind peripheral_interrupt_aggregator irq_agg_checker irq_agg_checker_i (
  .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .compare_ch5_evt_in(compare_ch5_evt_in), .waveform_gen_evt_in(waveform_gen_evt_in),
  .timer_one_ovf_in(timer_one_ovf_in), .timer_two_ovf_in(timer_two_ovf_in),
  .capture_compare_ch4_evt_in(capture_compare_ch4_evt_in),
  .compare_ch4_evt_in(compare_ch4_evt_in),
  .capture_compare_ch5_evt_in(capture_compare_ch5_evt_in),
  .take_in(take_in), .vector_out(vector_out));
`default_nettype wire

// ===== verif/cpu_take_model.sv
// CPU and transaction server side: accepts each shown vector after a delay.
// Assumes take_out drives the aggregator's take_in on the same clock.
`timescale 1ns/1ns
`default_nettype none
module cpu_take_model (
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  input  wire logic [1:0]           delay_in,
  input  wire irq_agg_pkg::vector_t vector_in,
  output var  logic                 take_out
);
  logic [1:0] wait_ff;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      take_out <= 1'b0;
      wait_ff  <= 2'h0;
    end else if (take_out) begin
      // One take per shown vector, so a refill is never swallowed
      take_out <= 1'b0;
      wait_ff  <= 2'h0;
    end else if (vector_in.valid) begin
      take_out <= (wait_ff == delay_in);
      wait_ff  <= wait_ff + 2'h1;
    end
  end
endmodule : cpu_take_model
`default_nettype wire

// ===== verif/peripheral_interrupt_aggregator_tb_top.sv
// Self-checking bench of the aggregator beside a CPU take model.
// Assumes the register map and vector layout of irq_agg_pkg.
`timescale 1ns/1ns
`default_nettype none
module peripheral_interrupt_aggregator_tb_top;
  irq_agg_pkg::vector_t vec;

  logic       clk_in     = 1'b0;
  logic       resetn_in  = 1'b0;
  logic [3:0] addr       = 4'h0;
  logic [7:0] wdata      = 8'h00;
  logic       wr         = 1'b0;
  logic       rd         = 1'b0;
  logic [8:0] ev         = 9'h000;
  logic [1:0] delay      = 2'h0;
  logic [7:0] rdata;
  logic       irq;
  logic       take;
  int         fail_count = 0;
  int         tests_run  = 0;
  int         cycles     = 0;
  localparam logic [3:0] MASK_A = irq_agg_pkg::OFS_SRC_MASK;
  localparam logic [3:0] PHI_A  = irq_agg_pkg::OFS_PEND_HIGH;

  always #10 clk_in = ~clk_in;

  peripheral_interrupt_aggregator peripheral_interrupt_aggregator_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .compare_ch5_evt_in(ev[0]),
    .waveform_gen_evt_in(ev[1]), .timer_one_ovf_in(ev[2]), .timer_two_ovf_in(ev[3]),
    .capture_compare_ch4_evt_in(ev[4]), .compare_ch4_evt_in(ev[5]),
    .capture_compare_ch5_evt_in(ev[6]), .server_done_ch5_in(ev[7]),
    .server_done_wg_in(ev[8]), .take_in(take), .vector_out(vec), .irq_out(irq));
  cpu_take_model cpu_take_model_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .delay_in(delay), .vector_in(vec),
    .take_out(take));

  task automatic report_and_stop();
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Run needs under a thousand cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic check_data(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected data at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check_data

  task automatic check_vec(input irq_agg_pkg::vector_t got, input irq_agg_pkg::vector_t exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected vector at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check_vec

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic expect_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd   <= 1'b0;
    #1 check_data(rdata, exp);
  endtask : expect_reg

  task automatic pulse(input int i);
    @(posedge clk_in);
    ev[i] <= 1'b1;
    @(posedge clk_in);
    ev[i] <= 1'b0;
  endtask : pulse

  task automatic expect_vec(input logic s, input logic [2:0] src, input logic [15:0] a,
                            input logic [4:0] p);
    int n;
    for (n = 0; n < 20 && vec.valid !== 1'b1; n++) @(posedge clk_in) #1;
    check_vec(vec, {1'b1, s, src, a, p});
    for (n = 0; n < 8 && take !== 1'b1; n++) @(posedge clk_in) #1;
    @(posedge clk_in);
  endtask : expect_vec

  task automatic s_reset();
    check_vec(vec, '0);
    expect_reg(irq_agg_pkg::OFS_SRC_PEND, 8'h00);
    expect_reg(PHI_A, 8'h00);
    expect_reg(4'hF, 8'h00);
    wr_reg(MASK_A, 8'hFF);
    expect_reg(MASK_A, 8'h0F);
  endtask : s_reset

  task automatic s_group();
    wr_reg(MASK_A, 8'h02);
    wr_reg(irq_agg_pkg::OFS_EN_HIGH, 8'h00);
    pulse(irq_agg_pkg::PS_CMP5);
    expect_reg(PHI_A, 8'h00);
    pulse(irq_agg_pkg::PS_WG);
    expect_reg(PHI_A, 8'h01);
    @(posedge clk_in);
    addr <= irq_agg_pkg::OFS_SRC_PEND;
    rd   <= 1'b1;
    @(posedge clk_in);
    #1 check_data(rdata, 8'h02);
    @(posedge clk_in);
    rd <= 1'b0;
    #1 check_data(rdata, 8'h00);
    check_data(vec.valid, 1'b0);
    wr_reg(irq_agg_pkg::OFS_SELECT, 8'h01);
    wr_reg(irq_agg_pkg::OFS_EN_HIGH, 8'h01);
    expect_vec(1'b1, 3'h0, irq_agg_pkg::PGRP_SRV_VEC, irq_agg_pkg::PGRP_SRV_PRIO);
    expect_reg(PHI_A, 8'h00);
    wr_reg(irq_agg_pkg::OFS_SELECT, 8'h00);
    delay <= 2'h3;
    pulse(irq_agg_pkg::PS_WG);
    expect_vec(1'b0, 3'h0, irq_agg_pkg::PGRP_INT_VEC, irq_agg_pkg::PGRP_INT_PRIO);
    delay <= 2'h0;
  endtask : s_group

  task automatic s_timer();
    wr_reg(MASK_A, 8'h04);
    wr_reg(irq_agg_pkg::OFS_EN_LOW, 8'h00);
    pulse(irq_agg_pkg::PS_TMR2);
    expect_reg(irq_agg_pkg::OFS_PEND_LOW, 8'h00);
    pulse(irq_agg_pkg::PS_TMR1);
    expect_reg(irq_agg_pkg::OFS_PEND_LOW, 8'h01);
    // Waveform bit from the last group event is still pending
    expect_reg(irq_agg_pkg::OFS_SRC_PEND, 8'h06);
    check_data(vec.valid, 1'b0);
    wr_reg(irq_agg_pkg::OFS_EN_LOW, 8'h01);
    expect_vec(1'b0, 3'h4, irq_agg_pkg::TIMER_OVERFLOW_GROUP_FLAG_INT_VEC, irq_agg_pkg::TIMER_OVERFLOW_GROUP_FLAG_INT_PRIO);
    expect_reg(irq_agg_pkg::OFS_PEND_LOW, 8'h00);
  endtask : s_timer

  task automatic s_service();
    wr_reg(MASK_A, 8'h01);
    pulse(7);
    expect_reg(irq_agg_pkg::OFS_SERVICE, 8'h01);
    wr_reg(irq_agg_pkg::OFS_SERVICE, 8'h00);
    pulse(8);
    expect_reg(irq_agg_pkg::OFS_SERVICE, 8'h00);
  endtask : s_service

  task automatic s_channels();
    int i;
    int s;
    wr_reg(irq_agg_pkg::OFS_EN_HIGH, 8'h0E);
    for (s = 0; s < 2; s++) begin
      wr_reg(irq_agg_pkg::OFS_SELECT, (s == 1) ? 8'h0E : 8'h00);
      for (i = 0; i < 3; i++) begin
        delay <= 2'(i);
        pulse(4 + i);
        expect_vec(s[0], 3'(i + 1), 16'h2034 + 16'(2 * i + 32 * s),
                   5'(10 + i + 15 * s));
      end
    end
  endtask : s_channels

  task automatic s_irq();
    wr_reg(irq_agg_pkg::OFS_EN_HIGH, 8'h00);
    wr_reg(irq_agg_pkg::OFS_IRQ_STAT, 8'h1F);
    wr_reg(irq_agg_pkg::OFS_IRQ_MASK, 8'h01);
    wr_reg(MASK_A, 8'h02);
    pulse(irq_agg_pkg::PS_WG);
    @(posedge clk_in);
    #1 check_data(irq, 1'b1);
    wr_reg(irq_agg_pkg::OFS_IRQ_STAT, 8'h01);
    @(posedge clk_in);
    #1 check_data(irq, 1'b0);
    wr_reg(PHI_A, 8'h00);
    expect_reg(PHI_A, 8'h00);
    wr_reg(irq_agg_pkg::OFS_IRQ_MASK, 8'h00);
    pulse(irq_agg_pkg::PS_WG);
    @(posedge clk_in);
    #1 check_data(irq, 1'b0);
    expect_reg(irq_agg_pkg::OFS_IRQ_STAT, 8'h01);
  endtask : s_irq

  initial begin
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    s_reset();
    s_group();
    s_timer();
    s_service();
    s_channels();
    s_irq();
    report_and_stop();
  end
endmodule : peripheral_interrupt_aggregator_tb_top
`default_nettype wire
